// [gdc_cfg_mem.v]
`timescale 1ns/10ps
// ****************************************************
// configuration byte store, registered read
// ****************************************************
module gdc_cfg_mem #(
  parameter AW = 6,
  parameter DW = 8,
  parameter DEPTH = 48,
  parameter [7:0] RST = 8'h01
) (
  // clock and reset
  input wire pclk,
  input wire presetn,
  // write side
  input wire we,
  input wire [AW-1:0] waddr,
  input wire [DW-1:0] wdata,
  // read side
  input wire [AW-1:0] raddr,
  output reg [DW-1:0] rdata_q
);
  reg [DW-1:0] mem_q [0:DEPTH-1];
  integer i;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      for (i = 0; i < DEPTH; i = i + 1) begin
        mem_q[i] <= RST[DW-1:0];
      end
      rdata_q <= {DW{1'b0}};
    end else begin
      if (we) begin
        mem_q[waddr] <= wdata;
      end
      rdata_q <= mem_q[raddr];
    end
  end
endmodule // gdc_cfg_mem

// [gdc_map.vh]
`ifndef GDC_MAP_VH
`define GDC_MAP_VH
// ****************************************************
// register indices (byte address is four times these)
// ****************************************************
`define GDC_DATA_FIRST 7'h4B
`define GDC_DATA_LAST 7'h50
`define GDC_IRQ_STS 7'h60
`define GDC_IRQ_EN 7'h61
`define GDC_IRQ_CLR 7'h62
`define GDC_CFG_P1B0 7'h23
`define GDC_CFG_P1B1 7'h24
`define GDC_CFG_P1B2 7'h25
`define GDC_CFG_P1B3 7'h26
`define GDC_CFG_P1B4 7'h27
`define GDC_CFG_P1B5 7'h29
`define GDC_CFG_P1B6 7'h2A
`define GDC_CFG_P1B7 7'h2B
`define GDC_CFG_P2B1 7'h2C
`define GDC_CFG_P2B2 7'h2D
`define GDC_CFG_P2B7 7'h32
`define GDC_CFG_P3B0 7'h33
`define GDC_CFG_P3B1 7'h34
`define GDC_CFG_P3B2 7'h35
`define GDC_CFG_P3B3 7'h36
`define GDC_CFG_P3B4 7'h37
`define GDC_CFG_P3B6 7'h39
`define GDC_CFG_P3B7 7'h3A
`define GDC_CFG_P4B0 7'h3B
`define GDC_CFG_P4B2 7'h3D
`define GDC_CFG_P4B4 7'h6E
`define GDC_CFG_P4B5 7'h6F
`define GDC_CFG_P4B6 7'h72
`define GDC_CFG_P4B7 7'h73
`define GDC_CFG_P5B0 7'h3F
`define GDC_CFG_P5B1 7'h40
`define GDC_CFG_P5B2 7'h41
`define GDC_CFG_P5B3 7'h42
`define GDC_CFG_P5B4 7'h43
`define GDC_CFG_P5B5 7'h44
`define GDC_CFG_P5B6 7'h45
`define GDC_CFG_P5B7 7'h46
`define GDC_CFG_P6B0 7'h47
`define GDC_CFG_P6B1 7'h48
`define GDC_CFG_P6B2 7'h54
`define GDC_CFG_P6B3 7'h55
`define GDC_CFG_P6B4 7'h56
`define GDC_CFG_P6B5 7'h57
`define GDC_CFG_P6B6 7'h58
`define GDC_CFG_P6B7 7'h59
// ****************************************************
// configuration byte fields and reset values
// ****************************************************
`define GDC_CFG_DIR 0
`define GDC_CFG_POL 1
`define GDC_CFG_ALT 2
`define GDC_CFG_OD 7
`define GDC_CFG_RST 8'h01
// ****************************************************
// port numbers: group g bit n is port (g-1)*8+n
// ****************************************************
`define GDC_PORT_MASK 48'hFFFFF5DF86FF
`define GDC_PORT_KBD_DATA 6'h09
`define GDC_PORT_KBD_CLK 6'h0A
`define GDC_PORT_MOUSE_DATA 6'h12
`define GDC_PORT_MOUSE_CLK 6'h13
`define GDC_PORT_EE0 6'h28
`define GDC_PORT_EE1 6'h29
`endif

// [gdc_top.v]
// Added by the designer: the APB slave port.
`timescale 1ns/10ps
`include "gdc_map.vh"
// What this block does
// - each port owns one data bit and one eight-bit config byte
// - six packed data registers, index 4B to 50, bit n of group k
// - input port reads return the current pin level
// - output port drives the value software last wrote
// - data bit captured into a holding latch on every read and write
// - each config byte sits at a fixed index from 23 to 73
// - keyboard and mouse pins default to bidirectional peripheral use
// - ports 40 and 41 raise an event on either pin edge
// - config bit 0 direction, bit 1 polarity, bit 7 driver type
// - direction 0 output, 1 input; polarity 1 inverts both ways
// - writes to input data bits ignored; outputs read last write
module gdc_top #(
  parameter NPORT = 48
) (
  // apb slave
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire pready,
  output wire pslverr,
  // general purpose pins, port p at bit p
  input wire [NPORT-1:0] gpio_in,
  output wire [NPORT-1:0] gpio_out,
  output wire [NPORT-1:0] gpio_oe,
  // keyboard and mouse controller side
  input wire [3:0] periph_drive_low,
  output wire [3:0] periph_line_in,
  // interrupt
  output wire both_edge_interrupt
);
  // ****************************************************
  // declarations
  // ****************************************************
  reg [NPORT-1:0] pin_s1_q;
  reg [NPORT-1:0] pin_s2_q;
  reg [1:0] ee_prev_q;
  reg [NPORT-1:0] out_q;
  reg [NPORT-1:0] hold_q;
  reg [NPORT-1:0] dir_q;
  reg [NPORT-1:0] pol_q;
  reg [NPORT-1:0] od_q;
  reg [NPORT-1:0] alt_q;
  reg [NPORT-1:0] pin_out_q;
  reg [NPORT-1:0] pin_oe_q;
  reg [NPORT-1:0] pin_out_d;
  reg [NPORT-1:0] pin_oe_d;
  reg [1:0] irq_sts_q;
  reg [1:0] irq_en_q;
  reg [31:0] prdata_q;
  reg pready_q;
  reg [6:0] slot;
  wire [6:0] idx;
  wire [5:0] cfg_port;
  wire cfg_hit;
  wire data_hit;
  wire irq_hit;
  wire hit;
  wire [2:0] grp;
  wire [5:0] grp_base;
  wire [NPORT-1:0] grp_sel;
  wire [NPORT-1:0] port_mask;
  wire [NPORT-1:0] per_mask;
  wire [NPORT-1:0] per_low;
  wire [NPORT-1:0] gpio_mode;
  wire [NPORT-1:0] view;
  wire [NPORT-1:0] wr_bits;
  wire [NPORT-1:0] out_next;
  wire [NPORT-1:0] view_next;
  wire [NPORT-1:0] hold_next;
  wire [7:0] cfg_rdata;
  wire acc_first;
  wire acc_done;
  wire wr_done;
  wire cfg_we;
  wire [1:0] ee_edge;
  wire [1:0] ee_now;
  wire [1:0] irq_clr;

  assign port_mask = `GDC_PORT_MASK;
  assign per_mask = ({{(NPORT-1){1'b0}}, 1'b1} << `GDC_PORT_KBD_DATA)
    | ({{(NPORT-1){1'b0}}, 1'b1} << `GDC_PORT_KBD_CLK)
    | ({{(NPORT-1){1'b0}}, 1'b1} << `GDC_PORT_MOUSE_DATA)
    | ({{(NPORT-1){1'b0}}, 1'b1} << `GDC_PORT_MOUSE_CLK);

  // ****************************************************
  // pin synchronisers
  // ****************************************************
  // pin levels are asynchronous; only the second stage reads the first
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_s1_q <= {NPORT{1'b0}};
      pin_s2_q <= {NPORT{1'b0}};
    end else begin
      pin_s1_q <= gpio_in;
      pin_s2_q <= pin_s1_q;
    end
  end

  assign periph_line_in = {pin_s2_q[`GDC_PORT_MOUSE_CLK],
    pin_s2_q[`GDC_PORT_MOUSE_DATA], pin_s2_q[`GDC_PORT_KBD_CLK],
    pin_s2_q[`GDC_PORT_KBD_DATA]};

  // ****************************************************
  // apb decode
  // ****************************************************
  // low address bits ignored: every register is one aligned word
  assign idx = paddr[8:2];
  assign data_hit = (paddr[11:9] == 3'h0) && (idx >= `GDC_DATA_FIRST)
    && (idx <= `GDC_DATA_LAST);
  assign irq_hit = (paddr[11:9] == 3'h0) && ((idx == `GDC_IRQ_STS)
    || (idx == `GDC_IRQ_EN) || (idx == `GDC_IRQ_CLR));
  assign cfg_hit = (paddr[11:9] == 3'h0) && slot[6];
  assign cfg_port = slot[5:0];
  assign hit = data_hit || irq_hit || cfg_hit;
  assign grp = idx[2:0] - 3'h3;
  assign grp_base = {grp, 3'h0};
  assign grp_sel = {{(NPORT-8){1'b0}}, 8'hFF} << grp_base;

  always @* begin
    case (idx)
      `GDC_CFG_P1B0: slot = {1'b1, 6'h00};
      `GDC_CFG_P1B1: slot = {1'b1, 6'h01};
      `GDC_CFG_P1B2: slot = {1'b1, 6'h02};
      `GDC_CFG_P1B3: slot = {1'b1, 6'h03};
      `GDC_CFG_P1B4: slot = {1'b1, 6'h04};
      `GDC_CFG_P1B5: slot = {1'b1, 6'h05};
      `GDC_CFG_P1B6: slot = {1'b1, 6'h06};
      `GDC_CFG_P1B7: slot = {1'b1, 6'h07};
      `GDC_CFG_P2B1: slot = {1'b1, 6'h09};
      `GDC_CFG_P2B2: slot = {1'b1, 6'h0A};
      `GDC_CFG_P2B7: slot = {1'b1, 6'h0F};
      `GDC_CFG_P3B0: slot = {1'b1, 6'h10};
      `GDC_CFG_P3B1: slot = {1'b1, 6'h11};
      `GDC_CFG_P3B2: slot = {1'b1, 6'h12};
      `GDC_CFG_P3B3: slot = {1'b1, 6'h13};
      `GDC_CFG_P3B4: slot = {1'b1, 6'h14};
      `GDC_CFG_P3B6: slot = {1'b1, 6'h16};
      `GDC_CFG_P3B7: slot = {1'b1, 6'h17};
      `GDC_CFG_P4B0: slot = {1'b1, 6'h18};
      `GDC_CFG_P4B2: slot = {1'b1, 6'h1A};
      `GDC_CFG_P4B4: slot = {1'b1, 6'h1C};
      `GDC_CFG_P4B5: slot = {1'b1, 6'h1D};
      `GDC_CFG_P4B6: slot = {1'b1, 6'h1E};
      `GDC_CFG_P4B7: slot = {1'b1, 6'h1F};
      `GDC_CFG_P5B0: slot = {1'b1, 6'h20};
      `GDC_CFG_P5B1: slot = {1'b1, 6'h21};
      `GDC_CFG_P5B2: slot = {1'b1, 6'h22};
      `GDC_CFG_P5B3: slot = {1'b1, 6'h23};
      `GDC_CFG_P5B4: slot = {1'b1, 6'h24};
      `GDC_CFG_P5B5: slot = {1'b1, 6'h25};
      `GDC_CFG_P5B6: slot = {1'b1, 6'h26};
      `GDC_CFG_P5B7: slot = {1'b1, 6'h27};
      `GDC_CFG_P6B0: slot = {1'b1, 6'h28};
      `GDC_CFG_P6B1: slot = {1'b1, 6'h29};
      `GDC_CFG_P6B2: slot = {1'b1, 6'h2A};
      `GDC_CFG_P6B3: slot = {1'b1, 6'h2B};
      `GDC_CFG_P6B4: slot = {1'b1, 6'h2C};
      `GDC_CFG_P6B5: slot = {1'b1, 6'h2D};
      `GDC_CFG_P6B6: slot = {1'b1, 6'h2E};
      `GDC_CFG_P6B7: slot = {1'b1, 6'h2F};
      default: slot = 7'h00;
    endcase
  end

  // ****************************************************
  // apb handshake
  // ****************************************************
  // one wait state so the config store read has time to settle
  assign acc_first = psel && penable && !pready_q;
  assign acc_done = psel && penable && pready_q;
  assign wr_done = acc_done && pwrite;
  assign pready = pready_q;
  assign pslverr = pready_q && !hit;
  assign prdata = prdata_q;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pready_q <= 1'b0;
    end else begin
      pready_q <= acc_first;
    end
  end

  // ****************************************************
  // configuration store
  // ****************************************************
  // one config byte per port
  assign cfg_we = wr_done && cfg_hit;

  gdc_cfg_mem #(
    .AW(6),
    .DW(8),
    .DEPTH(NPORT),
    .RST(`GDC_CFG_RST)
  ) u_cfg_mem (
    .pclk(pclk),
    .presetn(presetn),
    .we(cfg_we),
    .waddr(cfg_port),
    .wdata(pwdata[7:0]),
    .raddr(cfg_port),
    .rdata_q(cfg_rdata)
  );

  // control bits kept beside the store so every pin sees them at once
  // direction, polarity, select and driver type fields
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      dir_q <= {NPORT{1'b1}};
      pol_q <= {NPORT{1'b0}};
      od_q <= {NPORT{1'b0}};
      alt_q <= {NPORT{1'b0}};
    end else if (cfg_we) begin
      dir_q[cfg_port] <= pwdata[`GDC_CFG_DIR];
      pol_q[cfg_port] <= pwdata[`GDC_CFG_POL];
      od_q[cfg_port] <= pwdata[`GDC_CFG_OD];
      alt_q[cfg_port] <= pwdata[`GDC_CFG_ALT];
    end
  end

  // ****************************************************
  // data bits and holding latch
  // ****************************************************
  // peripheral use until the select bit picks general purpose
  assign gpio_mode = port_mask & ~(per_mask & ~alt_q);
  // inputs show the pin, polarity inverts it
  // bits with no port read as zero
  assign view = port_mask & ((dir_q & (pin_s2_q ^ pol_q))
    | (~dir_q & out_q));
  // only output bits of the addressed group take a write
  assign wr_bits = (wr_done && data_hit) ?
    (grp_sel & gpio_mode & ~dir_q) : {NPORT{1'b0}};
  assign out_next = (out_q & ~wr_bits)
    | ({6{pwdata[7:0]}} & wr_bits);
  assign view_next = port_mask & ((dir_q & (pin_s2_q ^ pol_q))
    | (~dir_q & out_next));
  assign hold_next = (hold_q & ~grp_sel) | (view_next & grp_sel);

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      out_q <= {NPORT{1'b0}};
      hold_q <= {NPORT{1'b0}};
    end else begin
      // last written value kept for the pin
      out_q <= out_next;
      // latch on read and on write
      if (data_hit && ((acc_first && !pwrite) || wr_done)) begin
        hold_q <= hold_next;
      end
    end
  end

  // ****************************************************
  // pin drivers
  // ****************************************************
  assign per_low =
    ({{(NPORT-1){1'b0}}, periph_drive_low[0]} << `GDC_PORT_KBD_DATA)
    | ({{(NPORT-1){1'b0}}, periph_drive_low[1]} << `GDC_PORT_KBD_CLK)
    | ({{(NPORT-1){1'b0}}, periph_drive_low[2]} << `GDC_PORT_MOUSE_DATA)
    | ({{(NPORT-1){1'b0}}, periph_drive_low[3]} << `GDC_PORT_MOUSE_CLK);

  genvar gi;
  generate
    for (gi = 0; gi < NPORT; gi = gi + 1) begin : g_pin
      always @* begin
        pin_out_d[gi] = 1'b0;
        pin_oe_d[gi] = 1'b0;
        if (port_mask[gi] && !gpio_mode[gi]) begin
          // open-drain both ways, line read back through sync
          pin_oe_d[gi] = per_low[gi];
        end else if (gpio_mode[gi] && !dir_q[gi]) begin
          // polarity applied on the way out
          pin_out_d[gi] = out_q[gi] ^ pol_q[gi];
          pin_oe_d[gi] = od_q[gi] ? !pin_out_d[gi] : 1'b1;
        end
      end
    end
  endgenerate

  // drivers registered so pins never glitch on decode changes
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_out_q <= {NPORT{1'b0}};
      pin_oe_q <= {NPORT{1'b0}};
    end else begin
      pin_out_q <= pin_out_d;
      pin_oe_q <= pin_oe_d;
    end
  end

  assign gpio_out = pin_out_q;
  assign gpio_oe = pin_oe_q;

  // ****************************************************
  // either edge events
  // ****************************************************
  assign ee_now = {pin_s2_q[`GDC_PORT_EE1], pin_s2_q[`GDC_PORT_EE0]};
  // rising or falling edge on ports 40 and 41
  assign ee_edge = ee_now ^ ee_prev_q;
  assign irq_clr = (wr_done && idx == `GDC_IRQ_CLR) ?
    pwdata[1:0] : 2'h0;

  // status counts whether or not enabled; a new edge beats a clear
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      ee_prev_q <= 2'h0;
      irq_sts_q <= 2'h0;
      irq_en_q <= 2'h0;
    end else begin
      ee_prev_q <= ee_now;
      irq_sts_q <= (irq_sts_q & ~irq_clr) | ee_edge;
      if (wr_done && idx == `GDC_IRQ_EN) begin
        irq_en_q <= pwdata[1:0];
      end
    end
  end

  assign both_edge_interrupt = |(irq_sts_q & irq_en_q);

  // ****************************************************
  // read data
  // ****************************************************
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      prdata_q <= 32'h00000000;
    end else if (acc_first) begin
      prdata_q <= 32'h00000000;
      if (!pwrite) begin
        if (data_hit) begin
          // read returns what was latched now
          prdata_q[7:0] <= hold_next[grp_base +: 8];
        end else if (cfg_hit) begin
          prdata_q[7:0] <= cfg_rdata;
        end else if (idx == `GDC_IRQ_STS) begin
          prdata_q[1:0] <= irq_sts_q;
        end else if (idx == `GDC_IRQ_EN) begin
          prdata_q[1:0] <= irq_en_q;
        end
      end
    end
  end
endmodule // gdc_top

// [gdc_top_properties.sv]
`timescale 1ns/10ps
// ****
// port level checks
// ****
module gdc_top_props #(
  parameter NPORT = 48
) (
  input wire pclk,
  input wire presetn,
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] prdata,
  input wire pready,
  input wire pslverr,
  input wire [NPORT-1:0] gpio_out
);
  wire wr_done = psel && penable && pready && pwrite;
  wire [6:0] idx = paddr[8:2];
  default clocking cb @(posedge pclk);
  endclocking
  default disable iff (!presetn);
  sequence s_first_access;
    psel && penable && !$past(penable);
  endsequence
  sequence s_ready_beat;
    psel && penable && pready;
  endsequence
  a_one_wait_state: assert property (s_first_access |=> s_ready_beat)
    else $error("ready not in second access cycle");
  a_ready_after_wait: assert property (pready |->
    penable && $past(penable) && $past(psel))
    else $error("ready without a wait state");
  a_ready_one_beat: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_err_with_ready: assert property (pslverr |-> pready)
    else $error("error flag without ready");
  a_high_bits_zero: assert property (pready && !pwrite |->
    prdata[31:8] == 24'h0)
    else $error("read data above byte not zero");
  a_bad_index_err: assert property (pready &&
    (paddr[11:9] != 3'h0 || idx == 7'h7F) |-> pslverr)
    else $error("unmapped access without error");
  a_data_index_ok: assert property (pready && paddr[11:9] == 3'h0 &&
    idx >= 7'h4B && idx <= 7'h50 |-> !pslverr)
    else $error("data register access flagged");
  a_err_read_zero: assert property (pready && pslverr && !pwrite |->
    prdata == 32'h0)
    else $error("refused read returned data");
  a_out_needs_write: assert property ($changed(gpio_out) |->
    $past(wr_done, 1) || $past(wr_done, 2) || $past(wr_done, 3))
    else $error("pin value moved without a write");
endmodule // gdc_top_props

bind gdc_top gdc_top_props #(.NPORT(NPORT)) gdc_top_props_i (
  .pclk(pclk),
  .presetn(presetn),
  .psel(psel),
  .penable(penable),
  .pwrite(pwrite),
  .paddr(paddr),
  .prdata(prdata),
  .pready(pready),
  .pslverr(pslverr),
  .gpio_out(gpio_out)
);

// [gdc_top_tb.sv]
`timescale 1ns/10ps
module gdc_top_tb;
  logic pclk = 1'b0;
  logic presetn = 1'b0;
  logic psel = 1'b0;
  logic penable = 1'b0;
  logic pwrite = 1'b0;
  logic [11:0] paddr = 12'h000;
  logic [31:0] pwdata = 32'h0;
  logic [31:0] prdata;
  logic pready;
  logic pslverr;
  logic [47:0] gpio_in = 48'h0;
  logic [47:0] gpio_out;
  logic [47:0] gpio_oe;
  logic [3:0] periph_drive_low = 4'h0;
  logic [3:0] periph_line_in;
  logic irq;
  logic [31:0] rd_v;
  logic err_v;
  int failures = 0;
  int samples_checked = 0;
  int cycles = 0;
  gdc_top #(.NPORT(48)) gdc_top_i (
    .pclk(pclk),
    .presetn(presetn),
    .psel(psel),
    .penable(penable),
    .pwrite(pwrite),
    .paddr(paddr),
    .pwdata(pwdata),
    .prdata(prdata),
    .pready(pready),
    .pslverr(pslverr),
    .gpio_in(gpio_in),
    .gpio_out(gpio_out),
    .gpio_oe(gpio_oe),
    .periph_drive_low(periph_drive_low),
    .periph_line_in(periph_line_in),
    .both_edge_interrupt(irq)
  );
  always #50 pclk = ~pclk;
  // ****
  // shared tasks
  // ****
  task automatic tally_and_finish();
    $display("failures %0d samples_checked %0d", failures, samples_checked);
    if (failures == 0 && samples_checked > 0) begin
      $display("DONE - PASS");
    end else begin
      $display("DONE - FAIL");
    end
    $finish;
  endtask
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 20000) begin
      failures++;
      tally_and_finish();
    end
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    samples_checked++;
    if (seen !== exp) begin
      failures++;
      $display("mismatch at %0t seen %h expected %h", $time, seen, exp);
    end
  endtask
  // index times four gives the byte address
  task automatic apb(input logic w, input logic [6:0] ix, input logic [7:0] d);
    @(posedge pclk);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= {3'h0, ix, 2'h0};
    pwdata <= {24'h0, d};
    @(posedge pclk);
    penable <= 1'b1;
    do @(posedge pclk); while (pready !== 1'b1);
    rd_v = prdata;
    err_v = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  task automatic rd_chk(input logic [6:0] ix, input logic [7:0] exp);
    apb(1'b0, ix, 8'h00);
    check(rd_v, {24'h0, exp});
  endtask
  task automatic bit_chk(input logic seen, input logic exp);
    check({31'h0, seen}, {31'h0, exp});
  endtask
  // ****
  // scenarios
  // ****
  task automatic t_cfg();
    logic [6:0] ix [5] = '{7'h23, 7'h2B, 7'h48, 7'h59, 7'h73};
    foreach (ix[i]) rd_chk(ix[i], 8'h01);
    apb(1'b1, 7'h73, 8'hC3);
    rd_chk(7'h73, 8'hC3);
    apb(1'b1, 7'h73, 8'h01);
  endtask
  task automatic t_input();
    gpio_in[39:32] <= 8'hA5;
    repeat (5) @(posedge pclk);
    rd_chk(7'h4F, 8'hA5);
    apb(1'b1, 7'h4F, 8'h5A);
    rd_chk(7'h4F, 8'hA5);
    apb(1'b1, 7'h3F, 8'h03);
    rd_chk(7'h4F, 8'hA4);
    apb(1'b1, 7'h3F, 8'h01);
    gpio_in[31:24] <= 8'hFF;
    repeat (5) @(posedge pclk);
    rd_chk(7'h4E, 8'hF5);
  endtask
  task automatic t_output();
    apb(1'b1, 7'h23, 8'h00);
    apb(1'b1, 7'h4B, 8'h01);
    repeat (2) @(posedge pclk);
    bit_chk(gpio_out[0], 1'b1);
    bit_chk(gpio_oe[0], 1'b1);
    rd_chk(7'h4B, 8'h01);
    apb(1'b1, 7'h23, 8'h02);
    repeat (2) @(posedge pclk);
    bit_chk(gpio_out[0], 1'b0);
    apb(1'b1, 7'h23, 8'h80);
    repeat (2) @(posedge pclk);
    bit_chk(gpio_oe[0], 1'b0);
    apb(1'b1, 7'h4B, 8'h00);
    repeat (2) @(posedge pclk);
    bit_chk(gpio_oe[0], 1'b1);
    apb(1'b1, 7'h23, 8'h01);
  endtask
  task automatic t_unmapped();
    apb(1'b1, 7'h7F, 8'hFF);
    bit_chk(err_v, 1'b1);
    rd_chk(7'h7F, 8'h00);
    bit_chk(err_v, 1'b1);
  endtask
  task automatic t_irq();
    apb(1'b1, 7'h61, 8'h03);
    gpio_in[40] <= 1'b1;
    repeat (6) @(posedge pclk);
    bit_chk(irq, 1'b1);
    rd_chk(7'h60, 8'h01);
    apb(1'b1, 7'h62, 8'h01);
    repeat (2) @(posedge pclk);
    bit_chk(irq, 1'b0);
    gpio_in[40] <= 1'b0;
    repeat (6) @(posedge pclk);
    bit_chk(irq, 1'b1);
    apb(1'b1, 7'h62, 8'h01);
    apb(1'b1, 7'h61, 8'h00);
    gpio_in[41] <= 1'b1;
    repeat (6) @(posedge pclk);
    bit_chk(irq, 1'b0);
    rd_chk(7'h60, 8'h02);
    apb(1'b1, 7'h61, 8'h02);
    repeat (2) @(posedge pclk);
    bit_chk(irq, 1'b1);
    apb(1'b1, 7'h62, 8'h02);
    repeat (2) @(posedge pclk);
    bit_chk(irq, 1'b0);
  endtask
  task automatic t_periph();
    // keyboard data line: controller pulls low, pin drives open drain
    periph_drive_low <= 4'h1;
    repeat (3) @(posedge pclk);
    bit_chk(gpio_oe[9], 1'b1);
    bit_chk(gpio_out[9], 1'b0);
    periph_drive_low <= 4'h0;
    gpio_in[10] <= 1'b1;
    repeat (5) @(posedge pclk);
    bit_chk(gpio_oe[9], 1'b0);
    bit_chk(periph_line_in[1], 1'b1);
    // peripheral pins ignore data writes until bit 2 selects gpio
    apb(1'b1, 7'h2C, 8'h00);
    apb(1'b1, 7'h4C, 8'h02);
    rd_chk(7'h4C, 8'h04);
    bit_chk(gpio_oe[9], 1'b0);
    apb(1'b1, 7'h2C, 8'h04);
    apb(1'b1, 7'h4C, 8'h02);
    repeat (2) @(posedge pclk);
    bit_chk(gpio_out[9], 1'b1);
    bit_chk(gpio_oe[9], 1'b1);
  endtask
  initial begin
    repeat (20) @(posedge pclk);
    presetn <= 1'b1;
    t_cfg();
    t_input();
    t_output();
    t_unmapped();
    t_irq();
    t_periph();
    tally_and_finish();
  end
endmodule // gdc_top_tb
